// [design/asr_consts.svh]
// timing and width constants for the asynchronous static memory host port
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH
`define ASR_CLK_PERIOD_NS 50
`define ASR_ADDR_W 17
`define ASR_DATA_W 8
`define ASR_WORDS 131072
// slowest speed grade: read and write cycle time, ns
`define ASR_READ_CYCLE_NS 25
`define ASR_WRITE_CYCLE_NS 25
`define ASR_WRITE_PULSE_NS 15
// recovery time after supply return equals the read cycle time
`define ASR_RECOVERY_NS 25
`define ASR_READ_CYC ((`ASR_READ_CYCLE_NS + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)
`define ASR_WRITE_CYC ((`ASR_WRITE_PULSE_NS + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)
`define ASR_RECOVERY_CYC ((`ASR_RECOVERY_NS + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)
`define ASR_CNT_W 4
`endif

// [design/asr_pkg.sv]
// types shared by the asynchronous static memory host port
package asr_pkg;
  typedef enum logic [4:0] {
    ASR_RECOVER = 5'h01,
    ASR_IDLE    = 5'h02,
    ASR_SETUP   = 5'h04,
    ASR_READ    = 5'h08,
    ASR_WRITE   = 5'h10
  } asr_state_t;

  typedef struct packed {
    logic        select_active_low;
    logic        select_active_high;
    logic        out_enable_n;
    logic        write_strobe_n;
  } asr_ctrl_t;
endpackage

// [design/asr_host.sv]
// host controller driving a 128k x 8 asynchronous static memory over its pins
// Functional notes
// - A write happens while write strobe and low select are low and high select is high.
// - A read drives data while write strobe and high select are high and low select and OE low.
// - A write may be framed by select or by write strobe; it spans all conditions together.
// - In a select-controlled read the address is valid no later than the last select going active.
// - The write strobe stays high for the whole of every read cycle.
`timescale 1ns/1ps
`default_nettype none
`include "asr_consts.svh"
module asr_host #(
  parameter int ADDR_W = `ASR_ADDR_W,
  parameter int DATA_W = `ASR_DATA_W
) (
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire logic              supply_ok,
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic      [DATA_W-1:0] rsp_rdata,
  output logic      [ADDR_W-1:0] mem_addr,
  output asr_pkg::asr_ctrl_t     mem_ctrl,
  input  wire logic [DATA_W-1:0] mem_data_in,
  output logic      [DATA_W-1:0] mem_data_out,
  output logic                   mem_data_oe
);
  localparam logic [`ASR_CNT_W-1:0] READ_CYC = (`ASR_CNT_W)'(`ASR_READ_CYC);
  localparam logic [`ASR_CNT_W-1:0] WRITE_CYC = (`ASR_CNT_W)'(`ASR_WRITE_CYC);
  localparam logic [`ASR_CNT_W-1:0] RECOV_CYC = (`ASR_CNT_W)'(`ASR_RECOVERY_CYC);

  ////////////////////////////////////////////////////////////////////////////////
  // supply-good pin synchroniser: change counts once stages two and three agree
  logic [2:0] sup_sync;
  logic       sup_good;
  logic       next_sup_good;
  always_comb
  begin
    next_sup_good = sup_good;
    if (sup_sync[1] == sup_sync[2])
    begin
      next_sup_good = sup_sync[2];
    end
  end
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sup_sync <= 3'h0;
      sup_good <= 1'b0;
    end
    else
    begin
      sup_sync <= {sup_sync[1:0], supply_ok};
      sup_good <= next_sup_good;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // access sequencer
  asr_pkg::asr_state_t    state;
  asr_pkg::asr_state_t    next_state;
  logic [`ASR_CNT_W-1:0]  cnt;
  logic [`ASR_CNT_W-1:0]  next_cnt;
  logic [ADDR_W-1:0]      next_mem_addr;
  logic [DATA_W-1:0]      next_mem_data_out;
  logic                   is_write;
  logic                   next_is_write;
  logic                   next_rsp_valid;
  logic [DATA_W-1:0]      next_rsp_rdata;

  assign req_ready = (state == asr_pkg::ASR_IDLE) && sup_good;

  always_comb
  begin
    next_state        = state;
    next_cnt          = cnt;
    next_mem_addr     = mem_addr;
    next_mem_data_out = mem_data_out;
    next_is_write     = is_write;
    next_rsp_valid    = 1'b0;
    next_rsp_rdata    = rsp_rdata;
    case (state)
      asr_pkg::ASR_RECOVER:
      begin
        if (!sup_good)
        begin
          next_cnt = RECOV_CYC;
        end
        else if (cnt <= 4'h1)
        begin
          next_state = asr_pkg::ASR_IDLE;
        end
        else
        begin
          next_cnt = cnt - 4'h1;
        end
      end
      asr_pkg::ASR_IDLE:
      begin
        if (!sup_good)
        begin
          next_state = asr_pkg::ASR_RECOVER;
          next_cnt   = RECOV_CYC;
        end
        else if (req_valid)
        begin
          next_mem_addr     = req_addr;
          next_mem_data_out = req_wdata;
          next_is_write     = req_write;
          next_state        = asr_pkg::ASR_SETUP;
        end
      end
      asr_pkg::ASR_SETUP:
      begin
        next_state = is_write ? asr_pkg::ASR_WRITE : asr_pkg::ASR_READ;
        next_cnt   = is_write ? WRITE_CYC : READ_CYC;
      end
      asr_pkg::ASR_READ:
      begin
        if (cnt <= 4'h1)
        begin
          next_rsp_rdata = mem_data_in;
          next_rsp_valid = 1'b1;
          next_state     = asr_pkg::ASR_IDLE;
        end
        else
        begin
          next_cnt = cnt - 4'h1;
        end
      end
      asr_pkg::ASR_WRITE:
      begin
        if (cnt <= 4'h1)
        begin
          next_rsp_valid = 1'b1;
          next_state     = asr_pkg::ASR_IDLE;
        end
        else
        begin
          next_cnt = cnt - 4'h1;
        end
      end
      default:
      begin
        next_state = asr_pkg::ASR_RECOVER;
        next_cnt   = RECOV_CYC;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state        <= asr_pkg::ASR_RECOVER;
      cnt          <= RECOV_CYC;
      mem_addr     <= '0;
      mem_data_out <= '0;
      is_write     <= 1'b0;
      rsp_valid    <= 1'b0;
      rsp_rdata    <= '0;
    end
    else
    begin
      state        <= next_state;
      cnt          <= next_cnt;
      mem_addr     <= next_mem_addr;
      mem_data_out <= next_mem_data_out;
      is_write     <= next_is_write;
      rsp_valid    <= next_rsp_valid;
      rsp_rdata    <= next_rsp_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin controls: both selects framed together, so the write is select-and-strobe framed
  logic in_access;
  assign in_access = (state == asr_pkg::ASR_READ) || (state == asr_pkg::ASR_WRITE);
  always_comb
  begin
    mem_ctrl.select_active_low  = !in_access;
    mem_ctrl.select_active_high = in_access;
    mem_ctrl.out_enable_n       = (state != asr_pkg::ASR_READ);
    mem_ctrl.write_strobe_n     = (state != asr_pkg::ASR_WRITE);
  end
  // drive data during write; setup state avoids bus fight with read turnaround
  assign mem_data_oe = (state == asr_pkg::ASR_WRITE);

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  property p_strobe_read;
    @(posedge core_clk) disable iff (!reset_n)
      !mem_ctrl.out_enable_n |-> mem_ctrl.write_strobe_n;
  endproperty
  a_strobe_read: assert property (p_strobe_read) else $error("strobe low during read");

  property p_addr_stable;
    @(posedge core_clk) disable iff (!reset_n)
      in_access |-> $stable(mem_addr);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved in access");

  property p_select_pair;
    @(posedge core_clk) disable iff (!reset_n)
      mem_ctrl.select_active_low == !mem_ctrl.select_active_high;
  endproperty
  a_select_pair: assert property (p_select_pair) else $error("selects disagree");

  property p_write_oe;
    @(posedge core_clk) disable iff (!reset_n)
      !mem_ctrl.write_strobe_n |-> (mem_data_oe && !mem_ctrl.select_active_low
                                    && mem_ctrl.select_active_high);
  endproperty
  a_write_oe: assert property (p_write_oe) else $error("write without select or data");

  property p_no_fight;
    @(posedge core_clk) disable iff (!reset_n)
      mem_data_oe |-> mem_ctrl.out_enable_n;
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("host drives during read");

  property p_setup_first;
    @(posedge core_clk) disable iff (!reset_n)
      $rose(in_access) |-> $past(state) == asr_pkg::ASR_SETUP;
  endproperty
  a_setup_first: assert property (p_setup_first) else $error("select without setup");

  property p_recover;
    @(posedge core_clk) disable iff (!reset_n)
      $rose(sup_good) |-> !in_access [*2];
  endproperty
  a_recover: assert property (p_recover) else $error("access before recovery");

  property p_read_done;
    @(posedge core_clk) disable iff (!reset_n)
      (state == asr_pkg::ASR_SETUP && !is_write) |=> ##1 rsp_valid;
  endproperty
  a_read_done: assert property (p_read_done) else $error("read answer late");

  c_read: cover property (@(posedge core_clk) disable iff (!reset_n)
    rsp_valid && !is_write);
  c_write: cover property (@(posedge core_clk) disable iff (!reset_n)
    rsp_valid && is_write);
  c_back: cover property (@(posedge core_clk) disable iff (!reset_n)
    rsp_valid ##1 (state == asr_pkg::ASR_SETUP));
endmodule
`default_nettype wire

// [tb/asr_mem_model.sv]
// behavioural 128k x 8 asynchronous static memory facing the host port
`timescale 1ns/1ps
`default_nettype none
module asr_mem_model (
  input  wire logic               core_clk,
  input  wire logic [16:0]        addr,
  input  wire asr_pkg::asr_ctrl_t ctrl,
  input  wire logic [7:0]         host_data,
  input  wire logic               host_oe,
  output logic      [7:0]         bus,
  output logic                    viol
);
  logic [7:0]  mem [0:131071];
  logic [7:0]  last;
  logic [16:0] prev_addr;
  logic        sel;
  logic        prev_sel;
  logic        rd_on;
  logic        wr_on;
  assign sel = !ctrl.select_active_low && ctrl.select_active_high;
  assign rd_on = sel && ctrl.write_strobe_n && !ctrl.out_enable_n;
  assign wr_on = sel && !ctrl.write_strobe_n;
  // nobody driving: show a changing pattern so a stale sample cannot pass
  assign bus = host_oe ? host_data : (rd_on ? mem[addr] : ~last);
  initial
  begin
    viol = 1'b0;
    last = 8'h00;
    for (int i = 0; i < 131072; i++) mem[i] = i[7:0] ^ 8'h5a;
  end
  always @(*) if (wr_on) mem[addr] = bus;
  always @(posedge core_clk)
  begin
    last <= bus;
    prev_sel <= sel;
    prev_addr <= addr;
    if (sel && prev_sel && addr !== prev_addr) viol <= 1'b1;
    if (sel && !ctrl.out_enable_n && !ctrl.write_strobe_n) viol <= 1'b1;
    if (host_oe && !wr_on) viol <= 1'b1;
  end
endmodule
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the asynchronous static memory host port
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic               core_clk = 1'b0;
  logic               reset_n = 1'b0;
  logic               supply_ok = 1'b1;
  logic               req_valid = 1'b0;
  logic               req_write = 1'b0;
  logic [16:0]        req_addr = '0;
  logic [7:0]         req_wdata = '0;
  logic               req_ready;
  logic               rsp_valid;
  logic               mem_data_oe;
  logic               viol;
  logic [7:0]         rsp_rdata;
  logic [7:0]         mem_data_out;
  logic [7:0]         mem_data_in;
  logic [16:0]        mem_addr;
  asr_pkg::asr_ctrl_t mem_ctrl;
  int                 err_count = 0;
  int                 samples_checked = 0;
  logic [7:0]         shadow [int];
  always #25 core_clk = ~core_clk;
  asr_host u_dut (.core_clk(core_clk), .reset_n(reset_n), .supply_ok(supply_ok),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .mem_addr(mem_addr), .mem_ctrl(mem_ctrl),
    .mem_data_in(mem_data_in), .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe));
  asr_mem_model u_mem (.core_clk(core_clk), .addr(mem_addr), .ctrl(mem_ctrl),
    .host_data(mem_data_out), .host_oe(mem_data_oe), .bus(mem_data_in), .viol(viol));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  function automatic logic [7:0] expect_rd(input logic [16:0] a);
    return shadow.exists(int'(a)) ? shadow[int'(a)] : (a[7:0] ^ 8'h5a);
  endfunction
  // one request; leaves at the settled point of the answer cycle
  task automatic access(input logic wr, input logic [16:0] a, input logic [7:0] d);
    int n;
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    for (n = 0; req_ready !== 1'b1 && n < 50; n++) tick();
    if (n == 50)
    begin
      err_count++;
      summarize();
    end
    tick();
    req_valid = 1'b0;
    for (n = 0; rsp_valid !== 1'b1 && n < 6; n++)
    begin
      if (mem_ctrl.select_active_low === 1'b0)
      begin
        check("addr", mem_addr, a);
        check("ctrl", {mem_ctrl.select_active_high, mem_ctrl.write_strobe_n}, {1'b1, !wr});
        check("oe_n", mem_ctrl.out_enable_n | wr, 1'b0 | wr);
        check("drive", mem_data_oe, wr);
        if (wr) check("wdata", mem_data_out, d);
      end
      tick();
    end
    if (n == 6)
    begin
      err_count++;
      summarize();
    end
    if (wr) shadow[int'(a)] = d;
    else check("rdata", rsp_rdata, expect_rd(a));
  endtask
  initial
  begin
    int n;
    logic [16:0] a;
    void'($urandom(32'hd3c5));
    repeat (16) @(posedge core_clk);
    #1 reset_n = 1'b1;
    access(1'b1, 17'h00000, 8'hff);
    access(1'b1, 17'h1ffff, 8'h00);
    access(1'b0, 17'h1ffff, 8'h00);
    access(1'b0, 17'h00000, 8'h00);
    access(1'b0, 17'h00123, 8'h00);
    for (int i = 0; i < 60; i++)
    begin
      a = (i % 3 == 0) ? 17'($urandom) : {13'h0a5, 4'($urandom)};
      access(1'($urandom), a, 8'($urandom));
    end
    supply_ok = 1'b0;
    repeat (6)
    begin
      tick();
      check("supply low sel", mem_ctrl.select_active_low, 1'b1);
    end
    supply_ok = 1'b1;
    for (n = 0; req_ready !== 1'b1 && n < 20; n++)
    begin
      check("recover sel", mem_ctrl.select_active_low, 1'b1);
      tick();
    end
    if (n == 20)
    begin
      err_count++;
      summarize();
    end
    check("recovery", n >= 1, 1'b1);
    access(1'b0, 17'h1ffff, 8'h00);
    reset_n = 1'b0;
    repeat (3)
    begin
      tick();
      check("reset sel", {mem_ctrl.select_active_low, mem_ctrl.select_active_high}, 2'b10);
      check("reset drive", mem_data_oe, 1'b0);
    end
    reset_n = 1'b1;
    access(1'b0, 17'h00000, 8'h00);
    access(1'b1, 17'h0a5a5, 8'h3c);
    access(1'b0, 17'h0a5a5, 8'h00);
    check("protocol", viol, 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
